// *** verilog/iwb_pkg.sv ***
package iwb_pkg;
   // Byte addresses of the low word of each 64-bit window register
   localparam logic [15:0] OFF_SPACE0_WINDOW_BASE = 16'hD120;
   localparam logic [15:0] OFF_SPACE1_WINDOW_BASE = 16'hD128;
   // High word sits one word above the low word
   localparam logic [15:0] OFF_HIGH_WORD = 16'h0004;
   localparam int NUM_WIN = 2;

   // Field positions within the 64-bit register
   localparam int POS_SWAP_DISABLE = 37;
   localparam int POS_ENDIAN_TRANSFER = 36;
   localparam int POS_BASE_MSB = 35;
   localparam int POS_BASE_LSB = 8;
   localparam int BASE_W = POS_BASE_MSB - POS_BASE_LSB + 1;

   // Values after reset, by endian mode
   localparam logic SWAP_DISABLE_RST_LE = 1'h1;
   localparam logic SWAP_DISABLE_RST_BE = 1'h0;
   localparam logic ENDIAN_TRANSFER_RST_LE = 1'h0;
   localparam logic ENDIAN_TRANSFER_RST_BE = 1'h1;
   localparam logic [BASE_W-1:0] BASE_RST = 28'h0000000;

   // Cycles after reset release before the synchronised strap is valid
   localparam logic [1:0] BOOT_WAIT = 2'h2;

   typedef struct packed {
      logic swap_disable;
      logic endian_transfer_enable;
      logic [BASE_W-1:0] base;
   } iwb_win_cfg_s;

   typedef struct packed {
      logic [1:0] strap_sync;
      logic [1:0] boot_cnt;
      logic loaded;
      logic wr_pend;
      logic wr_win;
      logic wr_hi;
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
      iwb_win_cfg_s [NUM_WIN-1:0] win;
   } iwb_state_s;
endpackage

// *** verilog/iwb_initiator_window_base_regs.sv ***
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module iwb_initiator_window_base_regs (
   input wire logic clk_sys, // System clock, 100 MHz
   input wire logic reset, // Synchronous reset, active high
   input wire logic big_endian_mode, // Endian strap pin, high for big-endian
   input wire logic hsel, // AHB slave select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write
   input wire logic [2:0] hsize, // AHB size, word only
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB bus ready
   output logic hreadyout, // AHB slave ready
   output logic hresp, // AHB response, always OKAY
   output logic [31:0] hrdata, // AHB read data
   output iwb_pkg::iwb_win_cfg_s [iwb_pkg::NUM_WIN-1:0] win_cfg // Per-window settings
);
   iwb_pkg::iwb_state_s state;
   iwb_pkg::iwb_state_s next_state;
   logic hit;
   logic hit_win;
   logic hit_hi;
   logic take;
   logic take_wr;
   logic take_rd;
   logic strap_be;
   logic boot_done;
   iwb_pkg::iwb_win_cfg_s rd_win;

   // The decoder and the field packing serve only this register layout
   if (iwb_pkg::NUM_WIN != 2) begin : g_chk_num_win
      $error("Window count must be two");
   end

   if (iwb_pkg::POS_BASE_LSB < 0 || iwb_pkg::POS_BASE_LSB > 31) begin : g_chk_base_lsb
      $error("Base field must start in the low word");
   end

   if (iwb_pkg::POS_BASE_MSB < 32) begin : g_chk_base_msb
      $error("Base field must end in the high word");
   end

   if (iwb_pkg::POS_ENDIAN_TRANSFER <= iwb_pkg::POS_BASE_MSB) begin : g_chk_endian_pos
      $error("Endian-transfer bit overlaps the base field");
   end

   if (iwb_pkg::POS_ENDIAN_TRANSFER > 63) begin : g_chk_endian_range
      $error("Endian-transfer bit lies outside the register");
   end

   if (iwb_pkg::POS_SWAP_DISABLE <= iwb_pkg::POS_BASE_MSB ||
       iwb_pkg::POS_SWAP_DISABLE > 63) begin : g_chk_swap_range
      $error("Swap-disable bit must sit in the high word above the base");
   end

   if (iwb_pkg::POS_SWAP_DISABLE == iwb_pkg::POS_ENDIAN_TRANSFER) begin : g_chk_swap_pos
      $error("Swap-disable and endian-transfer bits share a position");
   end

   // Defaults are loaded only after the strap has crossed both synchroniser stages
   if (iwb_pkg::BOOT_WAIT < 2'h2) begin : g_chk_boot_wait
      $error("Boot wait is shorter than the synchroniser");
   end

   // The decoder compares word addresses, so every offset must be word aligned
   if ((iwb_pkg::OFF_SPACE0_WINDOW_BASE & 16'h0003) != 16'h0000) begin : g_chk_align0
      $error("Space 0 offset is not word aligned");
   end

   if ((iwb_pkg::OFF_SPACE1_WINDOW_BASE & 16'h0003) != 16'h0000) begin : g_chk_align1
      $error("Space 1 offset is not word aligned");
   end

   if ((iwb_pkg::OFF_HIGH_WORD & 16'h0003) != 16'h0000 ||
       iwb_pkg::OFF_HIGH_WORD == 16'h0000) begin : g_chk_high_word
      $error("High word offset must be a non-zero multiple of four");
   end

   if (iwb_pkg::OFF_SPACE1_WINDOW_BASE == iwb_pkg::OFF_SPACE0_WINDOW_BASE ||
       iwb_pkg::OFF_SPACE1_WINDOW_BASE ==
          16'(iwb_pkg::OFF_SPACE0_WINDOW_BASE + iwb_pkg::OFF_HIGH_WORD)) begin : g_chk_overlap
      $error("Window registers overlap");
   end


   // Decodes a byte address into window index and word half
   function automatic logic [2:0] decode(input logic [15:0] a);
      logic [15:0] wa;
      wa = {a[15:2], 2'h0};
      if (wa == iwb_pkg::OFF_SPACE0_WINDOW_BASE) begin
         decode = 3'h4;
      end else if (wa == 16'(iwb_pkg::OFF_SPACE0_WINDOW_BASE + iwb_pkg::OFF_HIGH_WORD)) begin
         decode = 3'h5;
      end else if (wa == iwb_pkg::OFF_SPACE1_WINDOW_BASE) begin
         decode = 3'h6;
      end else if (wa == 16'(iwb_pkg::OFF_SPACE1_WINDOW_BASE + iwb_pkg::OFF_HIGH_WORD)) begin
         decode = 3'h7;
      end else begin
         decode = 3'h0;
      end
   endfunction

   // Reserved positions are never assigned, so they read back as zero
   function automatic logic [31:0] read_word(input iwb_pkg::iwb_win_cfg_s w, input logic hi);
      logic [63:0] full;
      full = 64'h0;
      full[iwb_pkg::POS_SWAP_DISABLE] = w.swap_disable;
      full[iwb_pkg::POS_ENDIAN_TRANSFER] = w.endian_transfer_enable;
      full[iwb_pkg::POS_BASE_MSB:iwb_pkg::POS_BASE_LSB] = w.base;
      if (hi) begin
         read_word = full[63:32];
      end else begin
         read_word = full[31:0];
      end
   endfunction

   function automatic iwb_pkg::iwb_win_cfg_s write_word(input iwb_pkg::iwb_win_cfg_s w,
                                                        input logic hi, input logic [31:0] d);
      logic [63:0] full;
      full = {32'h0, 32'h0};
      if (hi) begin
         full = {d, 32'h0};
         full[31:iwb_pkg::POS_BASE_LSB] = w.base[31-iwb_pkg::POS_BASE_LSB:0];
      end else begin
         full = {32'h0, d};
         full[iwb_pkg::POS_BASE_MSB:32] = w.base[iwb_pkg::BASE_W-1:32-iwb_pkg::POS_BASE_LSB];
         full[iwb_pkg::POS_SWAP_DISABLE] = w.swap_disable;
         full[iwb_pkg::POS_ENDIAN_TRANSFER] = w.endian_transfer_enable;
      end
      // Bits outside the three fields are simply not stored
      write_word.swap_disable = full[iwb_pkg::POS_SWAP_DISABLE];
      write_word.endian_transfer_enable = full[iwb_pkg::POS_ENDIAN_TRANSFER];
      write_word.base = full[iwb_pkg::POS_BASE_MSB:iwb_pkg::POS_BASE_LSB];
   endfunction

   // Defaults depend on the synchronised endian strap, not on the raw pin
   function automatic iwb_pkg::iwb_win_cfg_s default_cfg(input logic be);
      default_cfg.base = iwb_pkg::BASE_RST;
      if (be) begin
         default_cfg.swap_disable = iwb_pkg::SWAP_DISABLE_RST_BE;
         default_cfg.endian_transfer_enable = iwb_pkg::ENDIAN_TRANSFER_RST_BE;
      end else begin
         default_cfg.swap_disable = iwb_pkg::SWAP_DISABLE_RST_LE;
         default_cfg.endian_transfer_enable = iwb_pkg::ENDIAN_TRANSFER_RST_LE;
      end
   endfunction

   always_comb begin
      next_state = state;
      {hit, hit_win, hit_hi} = decode(haddr[15:0]);
      strap_be = state.strap_sync[1];
      boot_done = !state.loaded && (state.boot_cnt == iwb_pkg::BOOT_WAIT);
      take = state.loaded && hsel && htrans[1] && hready;
      take_wr = take && hwrite && hit;
      take_rd = take && !hwrite && hit;

      // Two-stage synchroniser; only the second stage feeds any logic
      next_state.strap_sync[0] = big_endian_mode;
      next_state.strap_sync[1] = state.strap_sync[0];

      // Strap is only trusted once it has crossed both synchroniser stages
      if (!state.loaded) begin
         next_state.boot_cnt = 2'(state.boot_cnt + 2'h1);
      end
      if (boot_done) begin
         next_state.loaded = 1'h1;
         next_state.hreadyout = 1'h1;
         for (int i = 0; i < iwb_pkg::NUM_WIN; i++) begin
            next_state.win[i] = default_cfg(strap_be);
         end
      end

      // Data phase of a write taken in the previous cycle
      if (state.wr_pend) begin
         next_state.win[state.wr_win] = write_word(state.win[state.wr_win], state.wr_hi,
                                                   hwdata);
      end

      // Address phase; unmapped writes are dropped here and never reach a window
      next_state.wr_pend = take_wr;
      if (take_wr) begin
         next_state.wr_win = hit_win;
         next_state.wr_hi = hit_hi;
      end

      // Read after the pending write so back-to-back write then read is coherent
      rd_win = next_state.win[hit_win];
      next_state.hrdata = 32'h0;
      if (take_rd) begin
         next_state.hrdata = read_word(rd_win, hit_hi);
      end

      // Every transfer, mapped or not, completes with OKAY
      next_state.hresp = 1'h0;

      if (reset) begin
         next_state = '0;
      end
   end

   // Synchronous reset is applied in the next-state logic above
   always_ff @(posedge clk_sys) begin
      state <= next_state;
   end

   assign hreadyout = state.hreadyout;
   assign hresp = state.hresp;
   assign hrdata = state.hrdata;
   // The swap datapath uses these as stored; in big-endian a set swap disable
   // passes doublewords in their original order.
   assign win_cfg = state.win;
endmodule // iwb_initiator_window_base_regs

// *** tb/iwb_properties.sv ***
`timescale 1ns/100ps
module iwb_properties (
   input wire logic clk_sys, // Clock
   input wire logic reset, // Reset
   input wire logic big_endian_mode, // Strap
   input wire logic hsel, // Select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write
   input wire logic [31:0] hwdata, // Write data
   input wire logic hreadyout, // Ready
   input wire logic hresp, // Response
   input wire logic [31:0] hrdata, // Read data
   input wire iwb_pkg::iwb_win_cfg_s [iwb_pkg::NUM_WIN-1:0] win_cfg // Settings
);
   logic pw;
   logic pr;
   logic [13:0] pa;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Data phase markers, so each check lines up with the word actually moved
   always_ff @(posedge clk_sys) begin
      pw <= !reset && hsel && htrans[1] && hreadyout && hwrite;
      pr <= !reset && hsel && htrans[1] && hreadyout && !hwrite;
      pa <= haddr[15:2];
   end
   property p_sw; pw && pa == 14'h3449 |=> win_cfg[0].swap_disable == $past(hwdata[5]); endproperty
   a_sw: assert property (p_sw) else $error("swap bit not stored");
   property p_et;
      pw && pa == 14'h3449 |=> win_cfg[0].endian_transfer_enable == $past(hwdata[4]);
   endproperty
   a_et: assert property (p_et) else $error("endian bit not stored");
   property p_ba; pw && pa == 14'h344A |=> win_cfg[1].base[23:0] == $past(hwdata[31:8]); endproperty
   a_ba: assert property (p_ba) else $error("base not stored");
   property p_sr; $rose(hreadyout) |-> win_cfg[0].swap_disable == !big_endian_mode; endproperty
   a_sr: assert property (p_sr) else $error("swap default wrong");
   property p_er;
      $rose(hreadyout) |-> win_cfg[1].endian_transfer_enable == big_endian_mode;
   endproperty
   a_er: assert property (p_er) else $error("endian default wrong");
   property p_br;
      $rose(hreadyout) |-> win_cfg[0].base == 28'h0 && win_cfg[1].base == 28'h0;
   endproperty
   a_br: assert property (p_br) else $error("base default wrong");
   property p_in; pw && pa == 14'h3449 |=> $stable(win_cfg[1]); endproperty
   a_in: assert property (p_in) else $error("windows not independent");
   property p_rz; pr |-> (pa[0] ? hrdata[31:6] == 26'h0 : hrdata[7:0] == 8'h0); endproperty
   a_rz: assert property (p_rz) else $error("reserved bits not zero");
   property p_hz; !pr |-> hrdata == 32'h0; endproperty
   a_hz: assert property (p_hz) else $error("read data outside data phase");
   property p_ok; hresp == 1'h0; endproperty
   a_ok: assert property (p_ok) else $error("response not OKAY");
endmodule // iwb_properties

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
   logic clk_sys = 1'h0, reset = 1'h1, big_endian_mode = 1'h0, hsel = 1'h0, hwrite = 1'h0;
   logic hreadyout, hresp;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   iwb_pkg::iwb_win_cfg_s [iwb_pkg::NUM_WIN-1:0] win_cfg;
   int fails = 0, checks_done = 0;
   always #5 clk_sys = ~clk_sys;
   // Single slave, so its ready is the bus ready
   iwb_initiator_window_base_regs DUT (.clk_sys(clk_sys), .reset(reset),
      .big_endian_mode(big_endian_mode), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .win_cfg(win_cfg));
   task automatic xf(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      r = hrdata;
      hsel <= 1'h0;
   endtask
   task automatic ck_cfg(input iwb_pkg::iwb_win_cfg_s g, input logic [29:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("Error %0t: settings %h want %h", $time, g, e);
      end
   endtask
   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      xf(1'h0, a, 32'h0);
      ck(r, e);
   endtask
   task automatic rst(input logic be);
      reset <= 1'h1;
      big_endian_mode <= be;
      repeat (8) @(posedge clk_sys);
      reset <= 1'h0;
   endtask
   task automatic conclude;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Tests need about 90 cycles; the limit leaves wide room
   initial begin
      #20000;
      fails++;
      conclude;
   end
   initial begin
      rst(1'h0);
      rd(32'hD124, 32'h20);
      rd(32'hD120, 32'h0);
      xf(1'h1, 32'hD124, 32'hFFFFFFFF);
      rd(32'hD124, 32'h3F);
      rd(32'hD12C, 32'h20);
      xf(1'h1, 32'hD120, 32'hFFFFFFFF);
      rd(32'hD120, 32'hFFFFFF00);
      ck_cfg(win_cfg[0], 30'h3FFFFFFF);
      rd(32'hD128, 32'h0);
      xf(1'h1, 32'hD128, 32'hABCDEF12);
      rd(32'hD128, 32'hABCDEF00);
      rd(32'hD120, 32'hFFFFFF00);
      xf(1'h1, 32'hD12C, 32'hFFFFFFDA);
      rd(32'hD12C, 32'h1A);
      ck_cfg(win_cfg[1], 30'h1AABCDEF);
      xf(1'h1, 32'hD124, 32'h0);
      rd(32'hD124, 32'h0);
      xf(1'h1, 32'hD124, 32'h20);
      rd(32'hD124, 32'h20);
      xf(1'h1, 32'hD130, 32'hFFFFFFFF);
      rd(32'hD130, 32'h0);
      $display("little-endian test done");
      rst(1'h1);
      rd(32'hD12C, 32'h10);
      rd(32'hD124, 32'h10);
      rd(32'hD128, 32'h0);
      rd(32'hD120, 32'h0);
      $display("big-endian test done");
      conclude;
   end
endmodule // testbench
bind iwb_initiator_window_base_regs iwb_properties u_props (.clk_sys(clk_sys), .reset(reset),
   .big_endian_mode(big_endian_mode), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .win_cfg(win_cfg));
